// *** logic/led_pwm_multichannel.sv ***
// multichannel led pulse-width generator with shadowed settings and register port
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/100ps
module led_pwm_multichannel #(
  parameter int NUM_CH = led_pwm_pkg::NUM_CH_DEF,
  parameter int CNT_W  = led_pwm_pkg::CNT_W_DEF
) (
  input  wire logic                            ref_clk,
  input  wire logic                            reset,
  input  wire logic [led_pwm_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [led_pwm_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [led_pwm_pkg::DATA_W-1:0]  reg_rdata,
  output logic      [NUM_CH-1:0]               led_sink_enable,
  output logic      [NUM_CH-1:0]               adc_sync,
  output logic                                 irq
);
  import led_pwm_pkg::*;

  localparam int CH_IDX_W = ADDR_W - CH_SHIFT;

  // shadow and active settings
  logic [CNT_W-1:0]    sh_div_ff;
  logic [CNT_W-1:0]    sh_per_ff;
  logic [CNT_W-1:0]    act_div_ff;
  logic [CNT_W-1:0]    act_per_ff;
  logic [CNT_W-1:0]    sh_rise_ff  [NUM_CH];
  logic [CNT_W-1:0]    sh_fall_ff  [NUM_CH];
  logic [CNT_W-1:0]    act_rise_ff [NUM_CH];
  logic [CNT_W-1:0]    act_fall_ff [NUM_CH];

  // timing state
  logic [CNT_W-1:0]    pre_ff;
  logic [CNT_W-1:0]    cnt_ff;
  logic [CNT_W-1:0]    eff_div;
  logic                tick_end;
  logic                boundary;
  logic                upd_req_ff;
  logic                upd_apply;

  // interrupt state
  logic [IRQ_W-1:0]    status_ff;
  logic [IRQ_W-1:0]    irq_en_ff;
  logic [IRQ_W-1:0]    irq_set;

  // register port decode
  logic                wr_ctrl;
  logic                wr_div;
  logic                wr_per;
  logic                wr_clr;
  logic                wr_en;
  logic                ch_hit;
  logic [CH_IDX_W-1:0] ch_idx;
  logic [DATA_W-1:0]   nxt_rdata;
  logic [NUM_CH-1:0]   nxt_on;

  assign wr_ctrl = reg_wr && (reg_addr == CTRL_OFS);
  assign wr_div  = reg_wr && (reg_addr == DIV_OFS);
  assign wr_per  = reg_wr && (reg_addr == PER_OFS);
  assign wr_clr  = reg_wr && (reg_addr == IRQ_CLR_OFS);
  assign wr_en   = reg_wr && (reg_addr == IRQ_EN_OFS);
  assign ch_hit  = (reg_addr >= CH_BASE);
  assign ch_idx  = CH_IDX_W'(reg_addr[ADDR_W-1:CH_SHIFT] - CH_BASE[ADDR_W-1:CH_SHIFT]);

  // prescaler and shared period counter
  assign eff_div   = (act_div_ff == '0) ? CNT_W'(1) : act_div_ff;
  assign tick_end  = (pre_ff >= CNT_W'(eff_div - CNT_W'(1)));
  assign boundary  = (cnt_ff >= act_per_ff);
  assign upd_apply = boundary && upd_req_ff;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pre_ff <= '0;
    end else if (boundary || tick_end) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= CNT_W'(pre_ff + CNT_W'(1));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_ff <= '0;
    end else if (boundary) begin
      cnt_ff <= '0;
    end else if (tick_end) begin
      cnt_ff <= CNT_W'(cnt_ff + CNT_W'(1));
    end
  end

  // global shadow and active divider / period
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sh_div_ff <= DIV_RST;
      sh_per_ff <= PER_RST;
    end else begin
      if (wr_div) begin
        sh_div_ff <= reg_wdata[CNT_W-1:0];
      end
      if (wr_per) begin
        sh_per_ff <= reg_wdata[CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      act_div_ff <= DIV_RST;
      act_per_ff <= PER_RST;
    end else if (upd_apply) begin
      act_div_ff <= sh_div_ff;
      act_per_ff <= sh_per_ff;
    end
  end

  // update request: a new write wins over the hardware clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      upd_req_ff <= 1'b0;
    end else if (wr_ctrl && reg_wdata[UPD_BIT]) begin
      upd_req_ff <= 1'b1;
    end else if (upd_apply) begin
      upd_req_ff <= 1'b0;
    end
  end

  // per channel stamps and pulse decision
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic           wr_rise;
    logic           wr_fall;
    logic [CNT_W-1:0] eff_fall;

    assign wr_rise = reg_wr && ch_hit && (ch_idx == CH_IDX_W'(i)) && !reg_addr[FALL_SEL];
    assign wr_fall = reg_wr && ch_hit && (ch_idx == CH_IDX_W'(i)) && reg_addr[FALL_SEL];

    always_ff @(posedge ref_clk) begin
      if (reset) begin
        sh_rise_ff[i] <= RISE_RST;
        sh_fall_ff[i] <= FALL_RST;
      end else begin
        if (wr_rise) begin
          sh_rise_ff[i] <= reg_wdata[CNT_W-1:0];
        end
        if (wr_fall) begin
          sh_fall_ff[i] <= reg_wdata[CNT_W-1:0];
        end
      end
    end

    always_ff @(posedge ref_clk) begin
      if (reset) begin
        act_rise_ff[i] <= RISE_RST;
        act_fall_ff[i] <= FALL_RST;
      end else if (upd_apply) begin
        act_rise_ff[i] <= sh_rise_ff[i];
        act_fall_ff[i] <= sh_fall_ff[i];
      end
    end

    // zero/zero is treated as a fall stamp of one
    assign eff_fall = (act_rise_ff[i] == '0 && act_fall_ff[i] == '0) ?
                      CNT_W'(1) : act_fall_ff[i];

    always_comb begin
      if (act_rise_ff[i] == '0 && act_fall_ff[i] == act_per_ff) begin
        nxt_on[i] = 1'b1;
      end else if (act_rise_ff[i] >= eff_fall) begin
        nxt_on[i] = 1'b0;
      end else begin
        // one extra clock at the fall count stretches the pulse by one cycle
        nxt_on[i] = (cnt_ff >= act_rise_ff[i]) &&
                    ((cnt_ff < eff_fall) || (cnt_ff == eff_fall && pre_ff == '0));
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      led_sink_enable <= '0;
      adc_sync        <= '0;
    end else begin
      led_sink_enable <= nxt_on;
      adc_sync        <= nxt_on;
    end
  end

  // sticky status, set wins over clear
  assign irq_set = {boundary, upd_apply};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status_ff <= '0;
    end else begin
      status_ff <= (status_ff & ~(wr_clr ? reg_wdata[IRQ_W-1:0] : '0)) | irq_set;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_en_ff <= '0;
    end else if (wr_en) begin
      irq_en_ff <= reg_wdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_ff & irq_en_ff);
    end
  end

  // read data, valid only the cycle after the strobe
  always_comb begin
    nxt_rdata = '0;
    if (ch_hit) begin
      if (int'(ch_idx) < NUM_CH) begin
        nxt_rdata[CNT_W-1:0] = reg_addr[FALL_SEL] ? sh_fall_ff[ch_idx] : sh_rise_ff[ch_idx];
      end
    end else begin
      case (reg_addr)
        CTRL_OFS:   nxt_rdata[UPD_BIT]     = upd_req_ff;
        DIV_OFS:    nxt_rdata[CNT_W-1:0]   = sh_div_ff;
        PER_OFS:    nxt_rdata[CNT_W-1:0]   = sh_per_ff;
        STATUS_OFS: nxt_rdata[IRQ_W-1:0]   = status_ff;
        IRQ_EN_OFS: nxt_rdata[IRQ_W-1:0]   = irq_en_ff;
        COUNT_OFS:  nxt_rdata[CNT_W-1:0]   = cnt_ff;
        OUT_OFS:    nxt_rdata[NUM_CH-1:0]  = led_sink_enable;
        default:    nxt_rdata              = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= '0;
    end
  end

  // helper: clocks since the last period boundary
  logic [2*CNT_W:0] len_ff;
  logic             seen_ff;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      len_ff  <= '0;
      seen_ff <= 1'b0;
    end else if (boundary) begin
      len_ff  <= (2*CNT_W+1)'(1);
      seen_ff <= 1'b1;
    end else begin
      len_ff  <= (2*CNT_W+1)'(len_ff + (2*CNT_W+1)'(1));
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  a_period_len: assert property (
    boundary && seen_ff |->
      len_ff == (2*CNT_W+1)'(act_per_ff) * (2*CNT_W+1)'(eff_div) + (2*CNT_W+1)'(1))
    else $error("period length differs from one plus period times divider");

  a_hold_active: assert property (
    !boundary |=> $stable(act_per_ff) && $stable(act_div_ff) &&
                  $stable(act_rise_ff[0]) && $stable(act_fall_ff[0]))
    else $error("active settings changed away from a period boundary");

  a_req_clear: assert property (
    upd_req_ff && boundary && !wr_ctrl |=> !upd_req_ff && status_ff[STAT_UPD_BIT])
    else $error("update request not cleared or event not flagged at boundary");

  a_req_sets: assert property (
    wr_ctrl && reg_wdata[UPD_BIT] |=> upd_req_ff)
    else $error("update request write did not take");

  a_full_on: assert property (
    act_rise_ff[0] == '0 && act_fall_ff[0] == act_per_ff |=> led_sink_enable[0])
    else $error("full on case did not hold output high");

  a_zero_zero: assert property (
    act_rise_ff[0] == '0 && act_fall_ff[0] == '0 && act_per_ff != '0 |=>
      led_sink_enable[0] == ($past(cnt_ff) == '0 ||
                             ($past(cnt_ff) == CNT_W'(1) && $past(pre_ff) == '0)))
    else $error("zero rise zero fall not treated as fall of one");

  a_full_off: assert property (
    act_rise_ff[0] >= act_fall_ff[0] && act_fall_ff[0] != '0 &&
      !(act_rise_ff[0] == '0 && act_fall_ff[0] == act_per_ff) |=> !led_sink_enable[0])
    else $error("off case drove output high");

  a_normal_on: assert property (
    act_rise_ff[0] < act_fall_ff[0] && cnt_ff == act_rise_ff[0] |=> led_sink_enable[0])
    else $error("output not on at rise stamp");

  a_normal_off: assert property (
    act_rise_ff[0] < act_fall_ff[0] && act_fall_ff[0] != act_per_ff &&
      cnt_ff == act_fall_ff[0] && pre_ff != '0 |=> !led_sink_enable[0])
    else $error("output still on after fall stamp");

  a_sync_match: assert property (
    adc_sync == led_sink_enable)
    else $error("adc sync differs from led output");

  a_count_range: assert property (
    cnt_ff <= act_per_ff || $past(upd_apply))
    else $error("shared counter ran past the period setting");

  a_irq_level: assert property (
    ##1 irq == $past(|(status_ff & irq_en_ff)))
    else $error("interrupt output does not follow enabled status");

  c_update_applied: cover property (upd_apply ##1 irq);
  c_led_rise:       cover property (!led_sink_enable[0] ##1 led_sink_enable[0]);
  c_led_fall:       cover property (led_sink_enable[0] ##1 !led_sink_enable[0]);
  c_set_clear_race: cover property (wr_clr && |irq_set);

endmodule

// *** logic/led_pwm_pkg.sv ***
// constants for the multichannel led pulse-width generator
package led_pwm_pkg;

  localparam int NUM_CH_DEF = 24;
  localparam int CNT_W_DEF  = 16;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int IRQ_W      = 2;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS    = 8'h00;
  localparam logic [ADDR_W-1:0] DIV_OFS     = 8'h04;
  localparam logic [ADDR_W-1:0] PER_OFS     = 8'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFS  = 8'h0c;
  localparam logic [ADDR_W-1:0] IRQ_CLR_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] IRQ_EN_OFS  = 8'h14;
  localparam logic [ADDR_W-1:0] COUNT_OFS   = 8'h18;
  localparam logic [ADDR_W-1:0] OUT_OFS     = 8'h1c;
  // channel n: rise stamp at CH_BASE + 8*n, fall stamp at CH_BASE + 8*n + 4
  localparam logic [ADDR_W-1:0] CH_BASE     = 8'h40;
  localparam int                CH_SHIFT    = 3;
  localparam int                FALL_SEL    = 2;

  // field positions
  localparam int UPD_BIT       = 0;
  localparam int STAT_UPD_BIT  = 0;
  localparam int STAT_WRAP_BIT = 1;

  // reset values
  localparam logic [CNT_W_DEF-1:0] DIV_RST  = 16'h0001;
  localparam logic [CNT_W_DEF-1:0] PER_RST  = 16'hffff;
  localparam logic [CNT_W_DEF-1:0] RISE_RST = 16'hffff;
  localparam logic [CNT_W_DEF-1:0] FALL_RST = 16'h0000;

endpackage

// *** sim/led_sink_model.sv ***
// partner model: led current sinks and adc sequencer edge watcher
`timescale 1ns/100ps
module led_sink_model #(
  parameter int NUM_CH = 24
) (
  input  wire logic                    ref_clk,
  input  wire logic                    clr,
  input  wire logic [NUM_CH-1:0]       led_sink_enable,
  input  wire logic [NUM_CH-1:0]       adc_sync,
  output logic      [NUM_CH-1:0][15:0] hi_cnt,
  output logic      [NUM_CH-1:0][15:0] rise_cnt,
  output logic      [15:0]             diff_cnt
);
  logic [NUM_CH-1:0] sync_prev_ff;
  always_ff @(posedge ref_clk) begin
    sync_prev_ff <= adc_sync;
    for (int i = 0; i < NUM_CH; i++) begin
      if (clr) begin
        hi_cnt[i] <= '0;
        rise_cnt[i] <= '0;
      end else begin
        // sink conducts only while its enable is high
        if (led_sink_enable[i] === 1'b1) begin
          hi_cnt[i] <= hi_cnt[i] + 16'h0001;
        end
        // sequencer starts conversions on a rising sync edge
        if (adc_sync[i] === 1'b1 && sync_prev_ff[i] === 1'b0) begin
          rise_cnt[i] <= rise_cnt[i] + 16'h0001;
        end
      end
    end
    // sync must follow the sink enable
    if (clr) diff_cnt <= '0;
    else if (adc_sync !== led_sink_enable) diff_cnt <= diff_cnt + 16'h0001;
  end
endmodule

// *** sim/led_pwm_multichannel_bench.sv ***
// self-checking bench for the multichannel led pulse-width generator
`timescale 1ns/100ps
module led_pwm_multichannel_bench;
  import led_pwm_pkg::*;
  localparam int NCH = 24;
  logic              ref_clk;
  logic              reset;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic [NCH-1:0]    led_sink_enable;
  logic [NCH-1:0]    adc_sync;
  logic              irq;
  logic              clr;
  logic [NCH-1:0][15:0] hi_cnt;
  logic [NCH-1:0][15:0] rise_cnt;
  logic [15:0]       diff_cnt;
  logic [DATA_W-1:0] rd;
  int                num_errors;
  int                total_checks;
  int                sh_r [NCH];
  int                sh_f [NCH];
  int                ac_r [NCH];
  int                ac_f [NCH];
  int                sh_d, sh_p, ac_d, ac_p;

  led_pwm_multichannel u_dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .led_sink_enable(led_sink_enable), .adc_sync(adc_sync), .irq(irq));
  led_sink_model #(.NUM_CH(NCH)) u_sink (.ref_clk(ref_clk), .clr(clr),
    .led_sink_enable(led_sink_enable), .adc_sync(adc_sync), .hi_cnt(hi_cnt),
    .rise_cnt(rise_cnt), .diff_cnt(diff_cnt));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic test_done();
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask

  task automatic chk_rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a);
    chk(name, exp, rd);
  endtask

  task automatic set_ch(input int c, input int r, input int f);
    wr_reg(CH_BASE + 8'(c << CH_SHIFT), 32'(r));
    wr_reg(CH_BASE + 8'(c << CH_SHIFT) + 8'(1 << FALL_SEL), 32'(f));
    sh_r[c] = r;
    sh_f[c] = f;
  endtask

  task automatic wait_irq(input int bound);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < bound) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (irq !== 1'b1) begin
      num_errors++;
      $display("MISMATCH irq_wait exp 1 got %b", irq);
      test_done();
    end
  endtask

  // update: request, wait for the clearing interrupt, then mirror the copy
  task automatic do_update(input int bound);
    logic [31:0] om;
    logic [31:0] ov;
    int          w;
    int          n;
    om = '0;
    ov = '0;
    n = 0;
    // short periods: start just after a boundary so the request is still pending when read
    if (ac_p * ac_d < 64) begin
      rd_reg(COUNT_OFS);
      while (rd !== 32'h0 && n < 64) begin
        rd_reg(COUNT_OFS);
        n++;
      end
      if (rd !== 32'h0) begin
        num_errors++;
        $display("MISMATCH count_sync exp 0 got %h", rd);
        test_done();
      end
    end
    // channels steadily on or off keep their level until the boundary
    for (int c = 0; c < NCH; c++) begin
      w = on_len(ac_r[c], ac_f[c]);
      om[c] = (w == 0 || w == ac_p * ac_d + 1);
      ov[c] = (w != 0);
    end
    wr_reg(CTRL_OFS, 32'h1);
    chk_rd("upd_pending", CTRL_OFS, 32'h1);
    rd_reg(OUT_OFS);
    chk("out_held", ov & om, rd & om);
    wait_irq(bound);
    chk_rd("upd_cleared", CTRL_OFS, 32'h0);
    rd_reg(STATUS_OFS);
    chk("stat_upd", 32'h1, 32'(rd[STAT_UPD_BIT]));
    ac_d = sh_d;
    ac_p = sh_p;
    ac_r = sh_r;
    ac_f = sh_f;
  endtask

  function automatic int on_len(input int r, input int f);
    if (r == 0 && f == ac_p) return ac_p * ac_d + 1;
    if (r == 0 && f == 0) return ac_d + 1;
    if (r >= f) return 0;
    return (f - r) * ac_d + 1;
  endfunction

  // measure a window of whole periods and compare every channel
  task automatic measure(input int nper);
    int plen;
    int w;
    plen = ac_p * ac_d + 1;
    repeat (plen) @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (nper * plen) @(posedge ref_clk);
    #1;
    for (int c = 0; c < NCH; c++) begin
      w = on_len(ac_r[c], ac_f[c]);
      chk("high_cycles", 32'(w * nper), 32'(hi_cnt[c]));
      chk("sync_rises", (w == 0 || w == plen) ? 32'h0 : 32'(nper), 32'(rise_cnt[c]));
    end
    chk("sync_copy", 32'h0, 32'(diff_cnt));
    rd_reg(COUNT_OFS);
    chk("count_upper", 32'h0, rd & 32'hffff0000);
    chk("count_le_per", 32'(rd <= 32'(ac_p)), 32'h1);
  endtask

  initial begin
    reset = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    clr = 1'b0;
    num_errors = 0;
    total_checks = 0;
    for (int c = 0; c < NCH; c++) begin
      sh_r[c] = 32'(RISE_RST);
      sh_f[c] = 32'(FALL_RST);
    end
    sh_d = 32'(DIV_RST);
    sh_p = 32'(PER_RST);
    ac_r = sh_r;
    ac_f = sh_f;
    ac_d = sh_d;
    ac_p = sh_p;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    chk_rd("div_rst", DIV_OFS, 32'(DIV_RST));
    chk_rd("per_rst", PER_OFS, 32'(PER_RST));
    chk_rd("rise23_rst", CH_BASE + 8'(23 << CH_SHIFT), 32'(RISE_RST));
    chk_rd("en_rst", IRQ_EN_OFS, 32'h0);
    chk_rd("unmapped", 8'h20, 32'h0);
    wr_reg(8'h24, 32'h5);
    chk_rd("unmapped_wr", 8'h24, 32'h0);
    // first set: div 2, period 5, every priority case
    // short periods keep the run brief; far above the supported 80 to 250 hz
    sh_d = 2;
    sh_p = 5;
    wr_reg(DIV_OFS, 32'h2);
    wr_reg(PER_OFS, 32'h5);
    set_ch(0, 1, 3);
    set_ch(1, 0, 5);
    set_ch(2, 0, 0);
    set_ch(3, 3, 3);
    set_ch(4, 4, 2);
    chk_rd("rise0_shadow", CH_BASE, 32'h1);
    wr_reg(IRQ_EN_OFS, 32'h1);
    do_update(70000);
    measure(3);
    // shadow change without update keeps the running shape
    set_ch(0, 1, 4);
    measure(2);
    wr_reg(IRQ_CLR_OFS, 32'h1);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("irq_cleared", 32'h0, 32'(irq));
    // second set: div 1, period 4, applied together
    sh_d = 1;
    sh_p = 4;
    wr_reg(DIV_OFS, 32'h1);
    wr_reg(PER_OFS, 32'h4);
    set_ch(1, 0, 4);
    do_update(40);
    measure(4);
    // masking: boundary event only raises irq once enabled
    wr_reg(IRQ_EN_OFS, 32'h0);
    wr_reg(IRQ_CLR_OFS, 32'h3);
    repeat (12) @(posedge ref_clk);
    #1;
    chk("irq_masked", 32'h0, 32'(irq));
    wr_reg(IRQ_EN_OFS, 32'h2);
    chk_rd("en_rb", IRQ_EN_OFS, 32'h2);
    wait_irq(20);
    chk_rd("stat_wrap", STATUS_OFS, 32'h2);
    chk("wrap_bit", 32'(rd[STAT_WRAP_BIT]), 32'h1);
    test_done();
  end
endmodule
